// ===== sim/ass_conv_model.sv
// Behavioural converter core answering start pulses
`timescale 1ns/100ps
`default_nettype none
module ass_conv_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic slow_i,
    input wire logic start_i,
    input wire logic [3:0] input_i,
    output logic done_o,
    output logic [11:0] data_o,
    output logic [15:0] count_o
);
    int left;
    // Odd conversions read four higher, so averages land between
    always @(posedge clk_i)
    begin
        done_o <= 1'b0;
        if (rst_i)
        begin
            left <= 0;
            count_o <= 16'h0000;
            data_o <= 12'h000;
        end
        else if (start_i)
            left <= slow_i ? 9 : 2;
        else if (left == 1)
        begin
            done_o <= 1'b1;
            data_o <= {input_i, 8'h00} + (count_o[0] ? 12'h004 : 12'h000);
            count_o <= count_o + 16'h0001;
            left <= 0;
        end
        else
        begin
            // Data outside the done and start cycles is not held
            data_o <= ~data_o;
            left <= left > 1 ? left - 1 : 0;
        end
    end
endmodule
`default_nettype wire

// ===== sim/ass_sequencer_assertions.sv
// Port checker of the sample sequencer control
`timescale 1ns/100ps
`default_nettype none
module ass_sequencer_assertions (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [7:0] bus_addr_i,
    input wire logic [31:0] bus_wdata_i,
    input wire logic bus_wr_i,
    input wire logic bus_rd_i,
    input wire logic conv_done_i,
    input wire logic [31:0] bus_rdata_o,
    input wire logic conv_start_o,
    input wire logic [3:0] conv_input_o,
    input wire logic [3:0] irq_o
);
    logic busy;
    logic [3:0] since;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    // Saturating age of the last finished conversion
    always_ff @(posedge clk_i)
    begin
        busy <= rst_i || conv_done_i ? 1'b0 : (conv_start_o ? 1'b1 : busy);
        since <= rst_i ? 4'hF : (conv_done_i ? 4'h0 : (since == 4'hF ? since : since + 4'h1));
    end
    sequence s_wr(logic [7:0] a);
        bus_wr_i && bus_addr_i == a && bus_wdata_i[3:0] == 4'hF;
    endsequence
    // Late results may legally set a flag again, so quiet cycles only
    sequence s_quiet;
        !conv_done_i && !$past(conv_done_i) ##1 !conv_done_i;
    endsequence
    property p_input;
        conv_start_o |-> conv_input_o <= ass_pkg::INPUT_TEMP;
    endproperty
    property p_one_out;
        conv_start_o |-> !busy ##1 !conv_start_o;
    endproperty
    property p_idle_rdata;
        !$past(bus_rd_i) |-> bus_rdata_o == 32'h00000000;
    endproperty
    property p_masked;
        bus_rd_i && bus_addr_i == ass_pkg::REG_INT_MASKED && $stable(irq_o)
            |=> $stable(irq_o) && bus_rdata_o[3:0] == irq_o;
    endproperty
    property p_disable;
        s_wr(ass_pkg::REG_INT_DISABLE) |-> ##2 irq_o == 4'h0;
    endproperty
    property p_clear;
        s_wr(ass_pkg::REG_INT_CLEAR) ##0 s_quiet |-> ##1 irq_o == 4'h0;
    endproperty
    property p_enable;
        s_wr(ass_pkg::REG_INT_ENABLE_SET) ##0 s_quiet |-> ##1 irq_o == 4'h0;
    endproperty
    property p_irq_cause;
        (irq_o & ~$past(irq_o)) != 4'h0 |-> since <= 4'h4;
    endproperty
    a_input: assert property (p_input) else $error("bad input select");
    a_one_out: assert property (p_one_out) else $error("overlapping start");
    a_idle_rdata: assert property (p_idle_rdata) else $error("read data not idle");
    a_masked: assert property (p_masked) else $error("masked status differs");
    a_disable: assert property (p_disable) else $error("irq after disable");
    a_clear: assert property (p_clear) else $error("irq after clear");
    a_enable: assert property (p_enable) else $error("pending kept on enable");
    a_irq_cause: assert property (p_irq_cause) else $error("irq without result");
endmodule
bind ass_sequencer ass_sequencer_assertions chk (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .bus_addr_i(bus_addr_i),
    .bus_wdata_i(bus_wdata_i),
    .bus_wr_i(bus_wr_i),
    .bus_rd_i(bus_rd_i),
    .conv_done_i(conv_done_i),
    .bus_rdata_o(bus_rdata_o),
    .conv_start_o(conv_start_o),
    .conv_input_o(conv_input_o),
    .irq_o(irq_o)
);
`default_nettype wire

// ===== sim/tb_adc_sample_sequencer_control.sv
// Self-checking bench of the sample sequencer control
`timescale 1ns/100ps
`default_nettype none
module tb_adc_sample_sequencer_control;
    localparam logic [7:0] CB = ass_pkg::REG_SEQ_CFG_BASE;
    localparam logic [7:0] SB = ass_pkg::REG_STEP_BASE;
    localparam logic [7:0] FB = ass_pkg::REG_FIFO_BASE;
    localparam logic [7:0] LB = ass_pkg::REG_LEVEL_BASE;
    localparam logic [7:0] TRG = ass_pkg::REG_PROC_TRIG;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    ass_pkg::ass_bus_req_t req = '0;
    logic [3:0] ext = 4'h0;
    logic slow = 1'b0;
    logic done;
    logic [11:0] cdata;
    logic [31:0] rdata;
    logic start;
    logic [3:0] csel;
    logic [3:0] irq;
    logic [15:0] cnt;
    logic [15:0] c0;
    logic [31:0] d;
    int failures = 0;
    int check_count = 0;
    always #12.5 clk_i = ~clk_i;
    ass_sequencer dut (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .bus_addr_i(req.addr),
        .bus_wdata_i(req.wdata),
        .bus_wr_i(req.wr),
        .bus_rd_i(req.rd),
        .ext_trig_i(ext),
        .conv_done_i(done),
        .conv_data_i(cdata),
        .bus_rdata_o(rdata),
        .conv_start_o(start),
        .conv_input_o(csel),
        .irq_o(irq)
    );
    ass_conv_model conv (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .slow_i(slow),
        .start_i(start),
        .input_i(csel),
        .done_o(done),
        .data_o(cdata),
        .count_o(cnt)
    );
    task automatic stop_test;
        if (failures == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e)
        begin
            failures++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk_i);
        req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge clk_i);
        req.wr <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk_i);
        req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clk_i);
        req.rd <= 1'b0;
        @(negedge clk_i);
        v = rdata;
    endtask
    task automatic rc(input string n, input logic [7:0] a, input logic [31:0] e);
        logic [31:0] v;
        rd(a, v);
        chk(n, e, v);
    endtask
    task automatic wl(input logic [7:0] s, input logic [3:0] n);
        logic [31:0] v;
        v = 32'h0;
        for (int i = 0; i < 2000 && v[3:0] < n; i++)
            rd(LB + s, v);
        chk("level", {28'h0, n}, {28'h0, v[3:0]});
    endtask
    task automatic ws(input string n, input logic [3:0] e);
        int i;
        i = 0;
        #1;
        while (start !== 1'b1 && i < 200)
        begin
            @(posedge clk_i);
            #1;
            i++;
        end
        chk(n, {28'h0, e}, {28'h0, csel});
        @(posedge clk_i);
        #1;
    endtask
    initial
    begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        rc("enable", ass_pkg::REG_SEQ_ENABLE, 32'h0);
        rc("factor", ass_pkg::REG_AVG_FACTOR, 32'h0);
        rc("step", SB, 32'h30);
        rc("unmapped", 8'hFF, ass_pkg::UNMAPPED_READ);
        wr(CB, 32'h20);
        wr(CB + 8'h1, 32'h14);
        wr(CB + 8'h2, 32'h00);
        wr(CB + 8'h3, 32'h30);
        wr(SB, 32'h05);
        wr(SB + 8'h1, 32'h08);
        wr(SB + 8'h2, 32'h35);
        wr(SB + 8'h08, 32'h36);
        wr(SB + 8'h10, 32'h37);
        wr(SB + 8'h18, 32'h32);
        wr(TRG, 32'h1);
        repeat (40) @(posedge clk_i);
        chk("idle conversions", 32'h0, {16'h0, cnt});
        wr(ass_pkg::REG_SEQ_ENABLE, 32'hF);
        c0 = cnt;
        wr(TRG, 32'h1);
        wl(8'h0, 4'h3);
        for (int k = 0; k < 3; k++)
            rc("sample", FB, {20'h0, k == 1 ? 4'h8 : 4'h5, 8'h00} +
                ((c0[0] ^ k[0]) ? 32'h4 : 32'h0));
        rc("raw", ass_pkg::REG_INT_RAW, 32'h1);
        chk("irq", 32'h0, {28'h0, irq});
        wr(TRG, 32'h5);
        ws("first input", 4'h7);
        ws("second input", 4'h5);
        wl(8'h0, 4'h3);
        wr(TRG, 32'h1);
        wl(8'h0, 4'h6);
        rc("overflow", ass_pkg::REG_OVERFLOW, 32'h1);
        wr(ass_pkg::REG_OVF_CLEAR, 32'hF);
        rc("overflow cleared", ass_pkg::REG_OVERFLOW, 32'h0);
        for (int k = 0; k < 6; k++)
            rd(FB, d);
        rd(FB + 8'h2, d);
        wr(TRG, 32'h2);
        repeat (40) @(posedge clk_i);
        rc("ignored trigger", LB + 8'h1, 32'h0);
        @(posedge clk_i);
        ext <= 4'h2;
        wl(8'h1, 4'h1);
        rd(FB + 8'h1, d);
        chk("external input", 32'h6, {28'h0, d[11:8]});
        @(posedge clk_i);
        slow <= 1'b1;
        for (int f = 2; f <= 64; f = f * 2)
        begin
            wr(ass_pkg::REG_AVG_FACTOR, 32'(f));
            c0 = cnt;
            wr(TRG, 32'h8);
            wl(8'h3, 4'h1);
            rc("full", LB + 8'h3, 32'h11);
            chk("conversions", 32'(f), {16'h0, cnt - c0});
            rc("average", FB + 8'h3, 32'h202);
        end
        wr(ass_pkg::REG_AVG_FACTOR, 32'h4);
        wr(ass_pkg::REG_INT_ENABLE_SET, 32'hF);
        rc("raw after enable", ass_pkg::REG_INT_RAW, 32'h0);
        c0 = cnt;
        wr(TRG, 32'h1);
        wl(8'h0, 4'h3);
        chk("shared factor", 32'hC, {16'h0, cnt - c0});
        chk("irq", 32'h1, {28'h0, irq});
        rc("masked", ass_pkg::REG_INT_MASKED, 32'h1);
        rc("enable on", ass_pkg::REG_INT_ENABLE, 32'hF);
        wr(ass_pkg::REG_INT_DISABLE, 32'hF);
        rc("masked off", ass_pkg::REG_INT_MASKED, 32'h0);
        chk("irq off", 32'h0, {28'h0, irq});
        rc("raw kept", ass_pkg::REG_INT_RAW, 32'h1);
        rc("enable off", ass_pkg::REG_INT_ENABLE, 32'h0);
        wr(ass_pkg::REG_MASKED_VIEW_BASE, 32'h1);
        rc("masked view", ass_pkg::REG_MASKED_VIEW_BASE, 32'h0);
        wr(ass_pkg::REG_MASKED_VIEW_BASE, 32'h0);
        rc("raw view", ass_pkg::REG_MASKED_VIEW_BASE, 32'h1);
        wr(ass_pkg::REG_INT_CLEAR, 32'hF);
        rc("raw cleared", ass_pkg::REG_INT_RAW, 32'h0);
        for (int k = 0; k < 3; k++)
            rc("avg sample", FB, {20'h0, k == 1 ? 4'h8 : 4'h5, 8'h02});
        // Free-running trigger keeps the short FIFO full
        wr(CB + 8'h3, 32'h3F);
        repeat (200) @(posedge clk_i);
        rc("always level", LB + 8'h3, 32'h11);
        rc("always overflow", ass_pkg::REG_OVERFLOW, 32'h8);
        stop_test;
    end
    // Run needs about 2500 cycles
    initial
    begin
        repeat (60000) @(posedge clk_i);
        failures++;
        stop_test;
    end
endmodule
`default_nettype wire

// ===== verilog/ass_averager.sv
// Averager that folds successive conversions into one result
`timescale 1ns/100ps
`default_nettype none
module ass_averager (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic clear_i,
    input wire logic [6:0] averaging_factor_i,
    input wire logic sample_valid_i,
    input wire logic [ass_pkg::SAMPLE_W-1:0] sample_i,
    output logic result_valid_o,
    output logic [ass_pkg::SAMPLE_W-1:0] result_o
);
    typedef struct packed {
        logic [ass_pkg::SUM_W-1:0] sum;
        logic [6:0] count;
        logic valid;
        logic [ass_pkg::SAMPLE_W-1:0] result;
    } ass_avg_state_t;

    ass_avg_state_t st;
    ass_avg_state_t next_st;
    logic [2:0] shift;
    logic [ass_pkg::SUM_W-1:0] total;

    always_comb
    begin
        next_st = st;
        next_st.valid = 1'b0;
        total = st.sum + ass_pkg::SUM_W'(sample_i);
        shift = 3'h0;
        for (int i = 1; i < 7; i++)
        begin
            if (averaging_factor_i[i])
            begin
                shift = 3'(i);
            end
        end
        if (clear_i)
        begin
            next_st.sum = '0;
            next_st.count = '0;
        end
        else if (sample_valid_i)
        begin
            if (shift == 3'h0)
            begin
                next_st.valid = 1'b1;
                next_st.result = sample_i;
            end
            else if ((st.count + 7'h01) == (7'h01 << shift))
            begin
                next_st.valid = 1'b1;
                next_st.result = ass_pkg::SAMPLE_W'(total >> shift);
                next_st.sum = '0;
                next_st.count = '0;
            end
            else
            begin
                next_st.sum = total;
                next_st.count = st.count + 7'h01;
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign result_valid_o = st.valid;
    assign result_o = st.result;
endmodule
`default_nettype wire

// ===== verilog/ass_pkg.sv
// Package with constants and types for the sample sequencer control block
package ass_pkg;
    localparam int NUM_SEQ = 4;
    localparam int NUM_STEP = 8;
    localparam int SAMPLE_W = 12;
    localparam int SUM_W = 18;
    localparam int AVG_W = 7;
    localparam logic [3:0] SEQ_DEPTH_0 = 4'h8;
    localparam logic [3:0] SEQ_DEPTH_1 = 4'h4;
    localparam logic [3:0] SEQ_DEPTH_2 = 4'h4;
    localparam logic [3:0] SEQ_DEPTH_3 = 4'h1;
    localparam logic [3:0] INPUT_TEMP = 4'h8;
    localparam logic [3:0] TRIG_PROCESSOR = 4'h0;
    localparam logic [3:0] TRIG_EXTERNAL = 4'h4;
    localparam logic [3:0] TRIG_ALWAYS = 4'hF;
    // Register offsets (word index in the low address bits)
    localparam logic [7:0] REG_SEQ_ENABLE = 8'h00;
    localparam logic [7:0] REG_AVG_FACTOR = 8'h01;
    localparam logic [7:0] REG_INT_RAW = 8'h02;
    localparam logic [7:0] REG_INT_ENABLE_SET = 8'h03;
    localparam logic [7:0] REG_INT_DISABLE = 8'h04;
    localparam logic [7:0] REG_INT_CLEAR = 8'h05;
    localparam logic [7:0] REG_INT_MASKED = 8'h06;
    localparam logic [7:0] REG_PROC_TRIG = 8'h07;
    localparam logic [7:0] REG_OVERFLOW = 8'h08;
    localparam logic [7:0] REG_OVF_CLEAR = 8'h09;
    localparam logic [7:0] REG_INT_ENABLE = 8'h0A;
    localparam logic [7:0] REG_SEQ_CFG_BASE = 8'h10;
    localparam logic [7:0] REG_STEP_BASE = 8'h20;
    localparam logic [7:0] REG_FIFO_BASE = 8'h40;
    localparam logic [7:0] REG_LEVEL_BASE = 8'h44;
    localparam logic [7:0] REG_AVG_SEL_BASE = 8'h48;
    localparam logic [7:0] REG_MASKED_VIEW_BASE = 8'h4C;
    // Step field layout: [3:0] input, [4] last step, [5] interrupt at step
    localparam int STEP_END_BIT = 4;
    localparam int STEP_IE_BIT = 5;
    // Sequence config layout: [3:0] trigger, [5:4] rank
    localparam int CFG_RANK_LSB = 4;
    localparam logic [5:0] CFG_RESET = 6'h00;
    localparam logic [5:0] STEP_RESET = 6'h30;
    localparam logic [6:0] AVG_RESET = 7'h00;
    localparam logic [31:0] UNMAPPED_READ = 32'h00000000;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } ass_bus_req_t;

    typedef struct packed {
        logic start;
        logic [3:0] input_sel;
    } ass_conv_req_t;

    typedef struct packed {
        logic done;
        logic [SAMPLE_W-1:0] data;
    } ass_conv_rsp_t;

    function automatic logic [3:0] ass_depth(input logic [1:0] seq);
        case (seq)
            2'h0: ass_depth = SEQ_DEPTH_0;
            2'h1: ass_depth = SEQ_DEPTH_1;
            2'h2: ass_depth = SEQ_DEPTH_2;
            default: ass_depth = SEQ_DEPTH_3;
        endcase
    endfunction
endpackage

// ===== verilog/ass_result_fifo.sv
// Result FIFO of one sample sequence, depth set by depth_i up to eight entries
`timescale 1ns/100ps
`default_nettype none
module ass_result_fifo (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [3:0] depth_i,
    input wire logic push_i,
    input wire logic [ass_pkg::SAMPLE_W-1:0] push_data_i,
    input wire logic pop_i,
    output logic [ass_pkg::SAMPLE_W-1:0] head_o,
    output logic [3:0] level_o,
    output logic full_o
);
    typedef struct packed {
        logic [2:0] wptr;
        logic [2:0] rptr;
        logic [3:0] level;
    } ass_fifo_state_t;

    ass_fifo_state_t st;
    ass_fifo_state_t next_st;
    logic [ass_pkg::SAMPLE_W-1:0] mem [0:7];
    logic do_push;
    logic do_pop;

    always_comb
    begin
        next_st = st;
        do_push = push_i && (st.level < depth_i);
        do_pop = pop_i && (st.level != 4'h0);
        if (do_push)
        begin
            next_st.wptr = (st.wptr + 3'h1) & 3'(depth_i - 4'h1);
        end
        if (do_pop)
        begin
            next_st.rptr = (st.rptr + 3'h1) & 3'(depth_i - 4'h1);
        end
        next_st.level = st.level + {3'h0, do_push} - {3'h0, do_pop};
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
        if (do_push)
        begin
            mem[st.wptr] <= push_data_i;
        end
    end

    assign head_o = mem[st.rptr];
    assign level_o = st.level;
    assign full_o = (st.level >= depth_i);
endmodule
`default_nettype wire

// ===== verilog/ass_sequencer.sv
// Top of the sample sequencer control: registers, arbitration, step walk
`timescale 1ns/100ps
`default_nettype none
module ass_sequencer (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [7:0] bus_addr_i,
    input wire logic [31:0] bus_wdata_i,
    input wire logic bus_wr_i,
    input wire logic bus_rd_i,
    input wire logic [3:0] ext_trig_i,
    input wire logic conv_done_i,
    input wire logic [ass_pkg::SAMPLE_W-1:0] conv_data_i,
    output logic [31:0] bus_rdata_o,
    output logic conv_start_o,
    output logic [3:0] conv_input_o,
    output logic [3:0] irq_o
);
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_START = 3'b010,
        ST_WAIT = 3'b100
    } ass_fsm_t;

    typedef struct packed {
        ass_fsm_t fsm;
        logic [3:0] seq_en;
        logic [6:0] averaging_factor;
        logic [3:0] int_raw;
        logic [3:0] int_en;
        logic [3:0] overflow;
        logic [3:0] pending;
        logic [3:0][5:0] seq_cfg;
        logic [3:0][7:0][5:0] step_cfg;
        logic [3:0] masked_view_select;
        logic [1:0] sequence_index;
        logic [2:0] step;
        logic done_seen;
        logic [3:0] ext_prev;
        logic [31:0] rdata;
        logic conv_start;
        logic [3:0] conv_input;
        logic [3:0] irq;
    } ass_state_t;

    ass_state_t st;
    ass_state_t next_st;
    ass_pkg::ass_bus_req_t req;
    logic [3:0] pop;
    logic [3:0] full;
    logic [3:0][3:0] level;
    logic [3:0][ass_pkg::SAMPLE_W-1:0] head;
    logic avg_valid;
    logic [ass_pkg::SAMPLE_W-1:0] avg_data;
    logic [3:0] trig_event;
    logic [3:0] cand;
    logic [1:0] winner;
    logic found;
    logic [3:0] trig_src;
    logic [5:0] cur_step;
    logic [1:0] sel;
    logic [31:0] rd_val;

    assign req = '{addr: bus_addr_i, wdata: bus_wdata_i, wr: bus_wr_i, rd: bus_rd_i};

    // Only the highest set bit counts, so a raw value like 6 acts as 4
    ass_averager u_avg (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .clear_i(st.fsm == ST_IDLE),
        .averaging_factor_i(st.averaging_factor),
        .sample_valid_i(conv_done_i && st.fsm == ST_WAIT && !st.done_seen),
        .sample_i(conv_data_i),
        .result_valid_o(avg_valid),
        .result_o(avg_data)
    );

    for (genvar g = 0; g < ass_pkg::NUM_SEQ; g++)
    begin : g_fifo
        ass_result_fifo u_fifo (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .depth_i(ass_pkg::ass_depth(2'(g))),
            .push_i(avg_valid && st.sequence_index == 2'(g)),
            .push_data_i(avg_data),
            .pop_i(pop[g]),
            .head_o(head[g]),
            .level_o(level[g]),
            .full_o(full[g])
        );
    end

    always_comb
    begin
        next_st = st;
        next_st.conv_start = 1'b0;
        next_st.rdata = '0;
        pop = '0;
        sel = req.addr[1:0];
        rd_val = ass_pkg::UNMAPPED_READ;
        next_st.ext_prev = ext_trig_i;
        // Trigger detection per sequence
        for (int s = 0; s < 4; s++)
        begin
            trig_src = st.seq_cfg[s][3:0];
            trig_event[s] = 1'b0;
            if (trig_src == ass_pkg::TRIG_ALWAYS)
            begin
                trig_event[s] = 1'b1;
            end
            else if (trig_src == ass_pkg::TRIG_EXTERNAL)
            begin
                trig_event[s] = ext_trig_i[s] && !st.ext_prev[s];
            end
            else if (trig_src == ass_pkg::TRIG_PROCESSOR)
            begin
                trig_event[s] = req.wr && req.addr == ass_pkg::REG_PROC_TRIG
                    && req.wdata[s];
            end
            if (trig_event[s] && st.seq_en[s])
            begin
                if (level[s] != 4'h0 || st.pending[s])
                begin
                    next_st.overflow[s] = 1'b1;
                end
                next_st.pending[s] = 1'b1;
            end
        end
        // Rank 0 wins; ranks are assumed distinct
        cand = st.pending & st.seq_en;
        found = 1'b0;
        winner = 2'h0;
        for (int r = 3; r >= 0; r--)
        begin
            for (int s = 0; s < 4; s++)
            begin
                if (cand[s] && st.seq_cfg[s][ass_pkg::CFG_RANK_LSB +: 2] == 2'(r))
                begin
                    found = 1'b1;
                    winner = 2'(s);
                end
            end
        end
        cur_step = st.step_cfg[st.sequence_index][st.step];
        case (st.fsm)
            ST_IDLE:
            begin
                if (found)
                begin
                    next_st.sequence_index = winner;
                    next_st.step = 3'h0;
                    next_st.pending[winner] = 1'b0;
                    next_st.fsm = ST_START;
                end
            end
            ST_START:
            begin
                next_st.conv_start = 1'b1;
                next_st.conv_input = cur_step[3:0];
                next_st.fsm = ST_WAIT;
            end
            ST_WAIT:
            begin
                // Averager answers one cycle after done, so decide then
                if (st.done_seen)
                begin
                    next_st.done_seen = 1'b0;
                    if (avg_valid)
                    begin
                        if (cur_step[ass_pkg::STEP_IE_BIT])
                        begin
                            next_st.int_raw[st.sequence_index] = 1'b1;
                        end
                        if (cur_step[ass_pkg::STEP_END_BIT] ||
                            4'({1'b0, st.step} + 4'h1) ==
                            ass_pkg::ass_depth(st.sequence_index))
                        begin
                            next_st.fsm = ST_IDLE;
                        end
                        else
                        begin
                            next_st.step = st.step + 3'h1;
                            next_st.fsm = ST_START;
                        end
                    end
                    else
                    begin
                        next_st.fsm = ST_START;
                    end
                end
                else if (conv_done_i)
                begin
                    next_st.done_seen = 1'b1;
                end
            end
            default:
            begin
                next_st.fsm = ST_IDLE;
            end
        endcase
        // Register writes; clears here sit below sets so sets win below
        if (req.wr)
        begin
            case (req.addr)
                ass_pkg::REG_SEQ_ENABLE: next_st.seq_en = req.wdata[3:0];
                ass_pkg::REG_AVG_FACTOR: next_st.averaging_factor = req.wdata[6:0];
                ass_pkg::REG_INT_ENABLE_SET:
                begin
                    next_st.int_raw = st.int_raw & ~req.wdata[3:0];
                    next_st.int_en = st.int_en | req.wdata[3:0];
                end
                ass_pkg::REG_INT_DISABLE:
                    next_st.int_en = st.int_en & ~req.wdata[3:0];
                ass_pkg::REG_INT_CLEAR:
                    next_st.int_raw = st.int_raw & ~req.wdata[3:0];
                ass_pkg::REG_OVF_CLEAR:
                    next_st.overflow = (st.overflow & ~req.wdata[3:0]) |
                        (next_st.overflow & ~st.overflow);
                default:
                begin
                    if (req.addr[7:2] == ass_pkg::REG_SEQ_CFG_BASE[7:2])
                    begin
                        next_st.seq_cfg[sel] = req.wdata[5:0];
                    end
                    else if (req.addr[7:5] == ass_pkg::REG_STEP_BASE[7:5])
                    begin
                        next_st.step_cfg[req.addr[4:3]][req.addr[2:0]] = req.wdata[5:0];
                    end
                    else if (req.addr[7:2] == ass_pkg::REG_MASKED_VIEW_BASE[7:2])
                    begin
                        next_st.masked_view_select[sel] = req.wdata[0];
                    end
                end
            endcase
        end
        // Interrupt set wins over a same-cycle clear
        if (st.fsm == ST_WAIT && avg_valid && cur_step[ass_pkg::STEP_IE_BIT])
        begin
            next_st.int_raw[st.sequence_index] = 1'b1;
        end
        if (req.rd)
        begin
            case (req.addr)
                ass_pkg::REG_SEQ_ENABLE: rd_val = {28'h0, st.seq_en};
                ass_pkg::REG_AVG_FACTOR: rd_val = {25'h0, st.averaging_factor};
                ass_pkg::REG_INT_RAW: rd_val = {28'h0, st.int_raw};
                ass_pkg::REG_INT_MASKED: rd_val = {28'h0, st.int_raw & st.int_en};
                ass_pkg::REG_INT_ENABLE: rd_val = {28'h0, st.int_en};
                ass_pkg::REG_OVERFLOW: rd_val = {28'h0, st.overflow};
                default:
                begin
                    if (req.addr[7:2] == ass_pkg::REG_FIFO_BASE[7:2])
                    begin
                        rd_val = {19'h00000, level[sel] == 4'h0, head[sel]};
                        pop[sel] = 1'b1;
                    end
                    else if (req.addr[7:2] == ass_pkg::REG_LEVEL_BASE[7:2])
                    begin
                        rd_val = {27'h0, full[sel], level[sel]};
                    end
                    else if (req.addr[7:2] == ass_pkg::REG_SEQ_CFG_BASE[7:2])
                    begin
                        rd_val = {26'h0, st.seq_cfg[sel]};
                    end
                    else if (req.addr[7:5] == ass_pkg::REG_STEP_BASE[7:5])
                    begin
                        rd_val = {26'h0, st.step_cfg[req.addr[4:3]][req.addr[2:0]]};
                    end
                    else if (req.addr[7:2] == ass_pkg::REG_MASKED_VIEW_BASE[7:2])
                    begin
                        rd_val = {31'h0, st.masked_view_select[sel] ?
                            st.int_raw[sel] & st.int_en[sel] : st.int_raw[sel]};
                    end
                end
            endcase
        end
        next_st.rdata = rd_val;
        next_st.irq = next_st.int_raw & next_st.int_en;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            st <= '0;
            st.fsm <= ST_IDLE;
            st.averaging_factor <= ass_pkg::AVG_RESET;
            st.seq_cfg <= {4{ass_pkg::CFG_RESET}};
            st.step_cfg <= {32{ass_pkg::STEP_RESET}};
        end
        else
        begin
            st <= next_st;
        end
    end

    assign bus_rdata_o = st.rdata;
    assign conv_start_o = st.conv_start;
    assign conv_input_o = st.conv_input;
    assign irq_o = st.irq;
endmodule
`default_nettype wire
